// *** rtl/sdt_top.sv ***
// Sinc decimation timing: rate, order, zero latency, settling and results
`timescale 1ns/1ns
module sdt_top (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_mod_bit,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic [sdt_pkg::DATA_W-1:0] o_result,
	output logic o_result_valid,
	output logic o_filter_reset
);
	localparam int W = sdt_pkg::ACC_W;
	localparam int NST = 4;

	////////////////////////////////////////////////////////////////////////////
	// Register file
	logic [9:0] rate_word;
	logic zero_latency;
	logic third_order_select;
	logic dual_notch_select;
	logic [1:0] channel;
	logic [31:0] status_word;
	logic [31:0] mode_word;
	logic [31:0] rd_mux;
	logic wr_mode;
	logic wr_chan;
	logic [9:0] rate_eff;
	assign wr_mode = i_wr && (i_addr == sdt_pkg::ADDR_MODE);
	assign wr_chan = i_wr && (i_addr == sdt_pkg::ADDR_CHAN);
	// Zero rate would stall the divider; treat it as the minimum
	assign rate_eff = (rate_word == '0) ? sdt_pkg::RATE_MIN : rate_word;

	// Mode register: software owns every field
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			rate_word <= sdt_pkg::RATE_RST;
			zero_latency <= 1'b0;
			third_order_select <= 1'b0;
			dual_notch_select <= 1'b0;
			channel <= '0;
		end else begin
			if (wr_mode) begin
				rate_word <= i_wdata[sdt_pkg::MODE_RATE_LSB +: sdt_pkg::RATE_W];
				zero_latency <= i_wdata[sdt_pkg::MODE_ZERO_LAT_BIT];
				third_order_select <= i_wdata[sdt_pkg::MODE_THIRD_BIT];
				dual_notch_select <= i_wdata[sdt_pkg::MODE_DUAL_BIT];
			end
			if (wr_chan) begin
				channel <= i_wdata[sdt_pkg::MODE_CHAN_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timing: decimation counter and settle counter
	logic [10:0] dec_cnt;
	logic [9:0] rate_cnt;
	logic [2:0] per_cnt;
	logic [2:0] need_periods;
	logic restart;
	logic period_end;
	logic dec_tick;
	logic [2:0] per_inc;
	logic conv_done;
	sdt_pkg::sdt_state_t state;
	sdt_pkg::sdt_state_t next_state;
	// Any mode or channel write restarts the filter like a channel change
	assign restart = wr_mode || wr_chan;
	assign dec_tick = (dec_cnt == 11'(sdt_pkg::DEC_PER_RATE - 1));
	assign period_end = dec_tick && (rate_cnt == rate_eff - 10'h001);
	assign need_periods = third_order_select ? sdt_pkg::ORDER3_PERIODS
		: sdt_pkg::ORDER4_PERIODS;
	assign per_inc = per_cnt + 3'h1;
	// In settle, or always under zero latency, a result waits the whole interval
	assign conv_done = period_end && ((state == sdt_pkg::SDT_RUN && !zero_latency)
		|| per_inc == need_periods);

	// Settle holds results until its last period; run emits one per period
	always_comb begin
		next_state = state;
		case (state)
			sdt_pkg::SDT_SETTLE: begin
				if (period_end && per_inc == need_periods && !zero_latency) begin
					next_state = sdt_pkg::SDT_RUN;
				end
			end
			sdt_pkg::SDT_RUN: begin
				next_state = sdt_pkg::SDT_RUN;
			end
			default: begin
				next_state = sdt_pkg::SDT_SETTLE;
			end
		endcase
		if (restart) begin
			next_state = sdt_pkg::SDT_SETTLE;
		end
	end

	// Counters restart with the filter
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || restart) begin
			state <= sdt_pkg::SDT_SETTLE;
			dec_cnt <= '0;
			rate_cnt <= '0;
			per_cnt <= '0;
		end else begin
			state <= next_state;
			dec_cnt <= dec_tick ? '0 : dec_cnt + 11'h001;
			if (dec_tick) begin
				rate_cnt <= period_end ? '0 : rate_cnt + 10'h001;
			end
			if (period_end) begin
				per_cnt <= (per_inc == need_periods) ? '0 : per_inc;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// CIC datapath: four integrators at clock rate, combs at output rate
	logic [W-1:0] integ [0:NST];
	logic [W-1:0] comb_in [0:NST];
	logic [W-1:0] comb_dly [0:NST-1];
	logic [W-1:0] comb_out;
	logic [W-1:0] chain_out;
	logic clr;
	assign clr = i_sys_rst || restart;
	assign integ[0] = {{(W-1){1'b0}}, i_mod_bit};

	genvar g;
	generate
		for (g = 0; g < NST; g++) begin : g_int
			sdt_integ #(.W(W)) u_int (
				.i_mclk(i_mclk),
				.i_clr(clr),
				.i_step(1'b1),
				.i_in(integ[g]),
				.o_acc(integ[g+1])
			);
		end
		for (g = 0; g < NST; g++) begin : g_comb
			always_ff @(posedge i_mclk) begin
				if (clr) begin
					comb_dly[g] <= '0;
				end else if (period_end) begin
					comb_dly[g] <= comb_in[g];
				end
			end
			assign comb_in[g+1] = comb_in[g] - comb_dly[g];
		end
	endgenerate
	// Third order taps one stage earlier; dual notch (fourth order only) subtracts half the last comb delay once more
	assign chain_out = third_order_select ? integ[NST-1] : integ[NST];
	assign comb_in[0] = chain_out;
	assign comb_out = third_order_select ? comb_in[NST-1]
		: (dual_notch_select ? comb_in[NST] - (comb_dly[NST-1] >>> 1) : comb_in[NST]);

	////////////////////////////////////////////////////////////////////////////
	// Result hand-off and read port
	assign mode_word = {18'h0_0000, dual_notch_select, third_order_select, zero_latency, 1'b0, rate_word};
	assign status_word = {27'h000_0000, per_cnt, state == sdt_pkg::SDT_RUN, 1'b0};
	assign rd_mux = (i_addr == sdt_pkg::ADDR_MODE) ? mode_word
		: (i_addr == sdt_pkg::ADDR_CHAN) ? {30'h0000_0000, channel}
		: (i_addr == sdt_pkg::ADDR_STATUS) ? status_word
		: (i_addr == sdt_pkg::ADDR_RESULT) ? {8'h00, o_result}
		: 32'h0000_0000;

	// Result strobe is one cycle; read data one cycle after the read strobe
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_result <= '0;
			o_result_valid <= 1'b0;
			o_filter_reset <= 1'b1;
			o_rdata <= '0;
		end else begin
			o_result_valid <= conv_done && !restart;
			if (conv_done && !restart) begin
				o_result <= comb_out[sdt_pkg::RESULT_SHIFT +: sdt_pkg::DATA_W];
			end
			o_filter_reset <= restart;
			o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	strobe_one_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_result_valid |=> !o_result_valid) else $error("valid strobe longer than one cycle");
	settle_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		restart |=> !o_result_valid [*8]) else $error("result during settle");
	order_reset_a: assert property (@(posedge i_mclk)
		i_sys_rst |=> !third_order_select) else $error("reset order not fourth");
	period_cnt_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		period_end |-> per_cnt < need_periods) else $error("period count overran");
	zl_run_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		zero_latency && !$past(restart) |-> state == sdt_pkg::SDT_SETTLE) else $error("zero latency left settle");
	zl_rate_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		zero_latency && conv_done |-> per_inc == need_periods) else $error("early zero latency result");
	order3_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		third_order_select |-> need_periods == 3'h3) else $error("third order periods wrong");
	restart_clr_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		wr_chan |=> dec_cnt == '0 && per_cnt == '0) else $error("channel change did not reset");
	rate_nz_a: assert property (@(posedge i_mclk) rate_eff != '0) else $error("rate zero");

	// Read data stand only in the cycle after a read strobe
	rdata_idle_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!i_rd |=> o_rdata == 32'h0000_0000) else $error("read data outside read");

	// Filter reset pulse follows every restart
	freset_pulse_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		restart |=> o_filter_reset) else $error("filter reset missing");

	// No filter reset pulse without a restart
	freset_low_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!restart |=> !o_filter_reset) else $error("spurious filter reset");

	// Results only ever leave at a period boundary
	valid_period_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_result_valid |-> $past(period_end)) else $error("result off period");

	// A period end short of the settle count emits nothing
	settle_early_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		state == sdt_pkg::SDT_SETTLE && period_end && per_inc != need_periods |=> !o_result_valid)
		else $error("result before settle");

	// Once running, every period yields a result
	run_each_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		state == sdt_pkg::SDT_RUN && !zero_latency && period_end && !restart |=> o_result_valid)
		else $error("running period lost");

	// Decimation counter never passes its wrap value
	dec_wrap_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		dec_cnt <= 11'(sdt_pkg::DEC_PER_RATE - 1)) else $error("decimation count overran");

	// Decimation counter steps by one between wraps
	dec_step_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!dec_tick && !restart |=> dec_cnt == $past(dec_cnt) + 11'h001) else $error("decimation step wrong");

	// Rate counter stays below the effective rate word
	rate_cnt_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		rate_cnt < rate_eff) else $error("rate count overran");

	// Period counter stays below the settle count
	per_cnt_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		per_cnt < need_periods) else $error("period count out of range");

	// Period counter advances by one at a non-final period end
	per_step_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		period_end && per_inc != need_periods && !restart |=> per_cnt == $past(per_inc))
		else $error("period step wrong");

	// Fourth order needs four periods
	order4_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!third_order_select |-> need_periods == sdt_pkg::ORDER4_PERIODS) else $error("fourth order periods wrong");

	// Result register moves only with its strobe
	result_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!o_result_valid |-> $stable(o_result)) else $error("result changed without strobe");

	// A restart clears the timing state
	restart_state_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		restart |=> per_cnt == '0 && rate_cnt == '0 && state == sdt_pkg::SDT_SETTLE)
		else $error("restart left timing state");

	// Mode write takes the zero latency bit
	zl_latch_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		wr_mode |=> zero_latency == $past(i_wdata[sdt_pkg::MODE_ZERO_LAT_BIT])) else $error("zero latency not taken");

	// Mode write takes the order select bit
	order_latch_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		wr_mode |=> third_order_select == $past(i_wdata[sdt_pkg::MODE_THIRD_BIT])) else $error("order not taken");

	// Mode write takes the dual notch bit
	dual_latch_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		wr_mode |=> dual_notch_select == $past(i_wdata[sdt_pkg::MODE_DUAL_BIT])) else $error("dual notch not taken");

	// Mode write takes the rate word
	rate_latch_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		wr_mode |=> rate_word == $past(i_wdata[9:0])) else $error("rate word not taken");

	// Channel write takes the channel field
	chan_latch_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		wr_chan |=> channel == $past(i_wdata[1:0])) else $error("channel not taken");

	// Reset keeps the strobe low and the filter reset high
	rst_out_a: assert property (@(posedge i_mclk)
		i_sys_rst |=> !o_result_valid && o_filter_reset) else $error("outputs wrong in reset");

	// Mode read returns the mode fields
	mode_read_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		i_rd && i_addr == sdt_pkg::ADDR_MODE |=> o_rdata == $past(mode_word)) else $error("mode read wrong");
endmodule : sdt_top

// *** include/sdt_pkg.sv ***
// Package: constants for the sinc decimation timing block
package sdt_pkg;
	localparam int RATE_W = 10;
	localparam int DEC_PER_RATE = 1024;
	localparam logic [9:0] RATE_MIN = 10'h001;
	localparam logic [9:0] RATE_RST = 10'h060;
	localparam logic [2:0] ORDER4_PERIODS = 3'h4;
	localparam logic [2:0] ORDER3_PERIODS = 3'h3;
	localparam int ACC_W = 32;
	localparam int DATA_W = 24;
	localparam int RESULT_SHIFT = 8;
	// Register offsets of the plain port
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_CHAN = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_RESULT = 4'h3;
	// Mode register field positions
	localparam int MODE_RATE_LSB = 0;
	localparam int MODE_ZERO_LAT_BIT = 11;
	localparam int MODE_THIRD_BIT = 12;
	localparam int MODE_DUAL_BIT = 13;
	localparam int MODE_CHAN_W = 2;
	typedef enum logic [1:0] {
		SDT_SETTLE = 2'b00,
		SDT_RUN = 2'b01
	} sdt_state_t;
endpackage : sdt_pkg

// *** rtl/sdt_integ.sv ***
// One integrator stage with clear and step enable, parameterised by width
`timescale 1ns/1ns
module sdt_integ #(
	parameter int W = 32
) (
	input wire logic i_mclk,
	input wire logic i_clr,
	input wire logic i_step,
	input wire logic [W-1:0] i_in,
	output logic [W-1:0] o_acc
);
	logic [W-1:0] next_acc;
	// Wrapping sum is intended: CIC stages rely on modular arithmetic
	assign next_acc = i_clr ? '0 : (i_step ? o_acc + i_in : o_acc);
	always_ff @(posedge i_mclk) begin
		o_acc <= next_acc;
	end
endmodule : sdt_integ

// *** testbench/sdt_mod_model.sv ***
// Behavioural modulator bitstream source for the decimation bench
`timescale 1ns/1ns
module sdt_mod_model (
	input wire logic i_mclk,
	input wire logic i_step,
	output logic o_bit
);
	logic [2:0] phase = 3'h0;
	// Free-running phase; the modulator clocks one bit per master clock
	always @(posedge i_mclk) begin
		phase <= phase + 3'h1;
	end
	// Density 5/8 before a step, 3/8 after, so a step really moves the input
	assign o_bit = i_step ? (phase < 3'h3) : (phase < 3'h5);
endmodule : sdt_mod_model

// *** testbench/sdt_top_tb.sv ***
// Self-checking testbench for the sinc decimation timing block
`timescale 1ns/1ns
module sdt_top_tb;
	logic i_mclk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic mod_step = 1'b0;
	logic mod_bit;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic [31:0] o_rdata;
	logic [sdt_pkg::DATA_W-1:0] o_result;
	logic o_result_valid;
	logic o_filter_reset;
	int errors = 0;
	int checks_done = 0;
	always #10 i_mclk = ~i_mclk;
	sdt_mod_model model (.i_mclk(i_mclk), .i_step(mod_step), .o_bit(mod_bit));
	sdt_top dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_mod_bit(mod_bit), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_result(o_result),
		.o_result_valid(o_result_valid), .o_filter_reset(o_filter_reset));
	////////////////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test;
		if (errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////////////
	// Plain port cycles, entered right after a rising edge
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 check(o_rdata, exp);
		@(posedge i_mclk);
	endtask : reg_rd
	// Bounded wait so a dead filter cannot hang the run
	task automatic wait_valid(output int c);
		c = 0;
		while (o_result_valid !== 1'b1 && c < 20000) begin
			@(posedge i_mclk);
			#1 c++;
		end
	endtask : wait_valid
	// Restart the filter by a write, then time the first result and the next gap
	// First result lands exactly n periods of 1024 x r clocks after the restart
	task automatic run_mode(input logic [3:0] a, input logic [31:0] d, input int n, input int r, input int gap);
		int c;
		reg_wr(a, d);
		#1 check(o_filter_reset, 1'b1);
		wait_valid(c);
		check(32'(c), 32'(n * sdt_pkg::DEC_PER_RATE * r));
		@(posedge i_mclk);
		#1 check(o_result_valid, 1'b0);
		wait_valid(c);
		check(32'(c + 1), 32'(gap));
		@(posedge i_mclk);
	endtask : run_mode
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic test_defaults;
		reg_rd(sdt_pkg::ADDR_MODE, 32'h0000_0060);
		reg_rd(4'hF, 32'h0000_0000);
	endtask : test_defaults
	// Every order, latency and notch setting, plus rate boundaries 0, 1 and 2
	task automatic test_modes;
		logic [31:0] modes [7] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0000, 32'h0000_1001,
			32'h0000_0801, 32'h0000_1801, 32'h0000_2001};
		int ns [7] = '{4, 4, 4, 3, 4, 3, 4};
		int rs [7] = '{1, 2, 1, 1, 1, 1, 1};
		int gaps [7] = '{1024, 2048, 1024, 1024, 4096, 3072, 1024};
		for (int i = 0; i < 7; i++) begin
			run_mode(sdt_pkg::ADDR_MODE, modes[i], ns[i], rs[i], gaps[i]);
		end
	endtask : test_modes
	// Channel change in both orders, then an input step mid-conversion
	task automatic test_channel_step;
		int c;
		run_mode(sdt_pkg::ADDR_CHAN, 32'h0000_0001, 4, 1, 1024);
		reg_wr(sdt_pkg::ADDR_MODE, 32'h0000_1001);
		run_mode(sdt_pkg::ADDR_CHAN, 32'h0000_0002, 3, 1, 1024);
		// Third order gain is 2^30; density 5/8 then 3/8 lands on fixed codes
		check(32'(o_result), 32'h0028_0000);
		mod_step <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			@(posedge i_mclk);
			#1 wait_valid(c);
		end
		check(32'(c + 1), 32'h0000_0400);
		check(32'(o_result), 32'h0018_0000);
	endtask : test_channel_step
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		repeat (5) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		@(posedge i_mclk);
		test_defaults();
		test_modes();
		test_channel_step();
		finish_test();
	end
	initial begin
		#1_800_000;
		errors++;
		finish_test();
	end
endmodule : sdt_top_tb
